// ==== core/seq_pkg.sv ====
// Shared constants and types for the sequencer pointer-control device
// and its external controller. Assumes a single 10 MHz system clock.
package seq_pkg;

   // Clock and timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int STAGGER_NS    = 3;
   localparam int STAGGER_CYC   =
      (STAGGER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PULSE_HI_CYC  = 2;
   localparam int PULSE_LO_CYC  = 2;
   localparam int SPI_HALF_CYC  = 4;

   // Serial frame: read flag, 15-bit address, 8-bit data
   localparam int FRAME_BITS = 24;
   localparam int INSTR_BITS = 16;

   // Device register addresses
   localparam logic [14:0] INTF_CFG_ADDR    = 15'h0000;
   localparam logic [14:0] TX_SETUP_ADDR    = 15'h0016;
   localparam logic [14:0] TX_DEPTH_ADDR    = 15'h0017;
   localparam logic [14:0] MULT_SETUP_ADDR  = 15'h0018;
   localparam logic [14:0] SOFT_CTRL_ADDR   = 15'h0044;
   localparam logic [14:0] TX_STATUS_ADDR   = 15'h0045;
   localparam logic [14:0] MULT_STATUS_ADDR = 15'h0046;

   // Device field positions
   localparam int SERIAL_OUT_ACTIVE_BIT = 4;
   localparam int SERIAL_OUT_MIRROR_BIT = 3;
   localparam int SLEEP_LINK_BIT        = 6;
   localparam int SLEEP_HOLD_BIT        = 5;
   localparam int LATCH_BYPASS_BIT      = 4;
   localparam int SOFT_RESET_BIT        = 1;
   localparam int SOFT_ADV_BIT          = 0;

   // Device reset values
   localparam logic [7:0] INTF_CFG_RST   = 8'h18;
   localparam logic [7:0] TX_SETUP_RST   = 8'h00;
   localparam logic [7:0] TX_DEPTH_RST   = 8'h00;
   localparam logic [7:0] MULT_SETUP_RST = 8'h00;

   // Controller APB offsets and fields
   localparam logic [11:0] PULSE_OFS   = 12'h000;
   localparam logic [11:0] SPI_CMD_OFS = 12'h004;
   localparam logic [11:0] STATUS_OFS  = 12'h008;
   localparam logic [11:0] CFG_OFS     = 12'h00C;
   localparam int PB_TX_RESET   = 0;
   localparam int PB_TX_ADV     = 1;
   localparam int PB_MULT_RESET = 2;
   localparam int PB_MULT_ADV   = 3;
   localparam int PB_WAKE       = 4;
   localparam logic CFG_RST     = 1'b0;

   typedef enum logic [1:0] {
      SPI_IDLE  = 2'b00,
      SPI_SHIFT = 2'b01,
      SPI_STOP  = 2'b11
   } spi_state_t;

   typedef enum logic [1:0] {
      P_IDLE = 2'b00,
      P_LEAD = 2'b01,
      P_HIGH = 2'b11,
      P_LOW  = 2'b10
   } pulse_state_t;

   // Next pointer on advance: past the zero-indexed depth wraps to 1
   function automatic logic [7:0] step_ptr(input logic [7:0] ptr,
                                           input logic [7:0] depth);
      return (ptr > depth) ? 8'h01 : ptr + 8'h01;
   endfunction : step_ptr

endpackage : seq_pkg

// ==== core/seq_link_if.sv ====
// Pulse lines and serial lines between controller and device.
// Resolves the shared data line and the output line from enables.
`timescale 1ns/1ps
interface seq_link_if;
   logic tx_reset;
   logic tx_adv;
   logic mult_reset;
   logic mult_adv;
   logic sclk;
   logic cs_n;
   logic host_sdio_out;
   logic host_sdio_oe;
   logic dev_sdio_out;
   logic dev_sdio_oe;
   logic dev_sdo_out;
   logic dev_sdo_oe;
   logic sdio_level;
   logic sdo_level;

   // Idle lines read high, as with a pull-up
   assign sdio_level = host_sdio_oe ? host_sdio_out :
                       (dev_sdio_oe ? dev_sdio_out : 1'b1);
   assign sdo_level  = dev_sdo_oe ? dev_sdo_out : 1'b1;

   modport host (
      output tx_reset, tx_adv, mult_reset, mult_adv, sclk, cs_n,
      output host_sdio_out, host_sdio_oe,
      input  sdio_level, sdo_level
   );

   modport device (
      input  tx_reset, tx_adv, mult_reset, mult_adv, sclk, cs_n,
      input  sdio_level,
      output dev_sdio_out, dev_sdio_oe, dev_sdo_out, dev_sdo_oe
   );
endinterface : seq_link_if

// ==== core/pulse_edge.sv ====
// Rising and falling edge detector for a group of five pin levels.
// Assumes the levels are already synchronous to clk_in.
`timescale 1ns/1ps
module pulse_edge (
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       srst_in,
   // Levels and edges
   input  wire logic [4:0] level_in,
   output logic      [4:0] rise_out,
   output logic      [4:0] fall_out
);
   logic [4:0] prev_reg;

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         prev_reg <= 5'h00;
      end else begin
         prev_reg <= level_in;
      end
   end

   assign rise_out = level_in & ~prev_reg;
   assign fall_out = ~level_in & prev_reg;
endmodule : pulse_edge

// ==== core/seq_device.sv ====
// Device end: two state sequencers with sleep link, sleep hold,
// output latch and bypass, plus a serial register slave.
// Assumes pulse and serial lines are synchronous to CLK_IN.
`timescale 1ns/1ps
module seq_device
   import seq_pkg::*;
(
   // Clock and reset
   input  wire logic  CLK_IN,
   input  wire logic  SRST_IN,
   // Link to controller
   seq_link_if.device LINK,
   // Applied states to the controlled blocks
   output logic [7:0] TX_STATE_OUT,
   output logic [4:0] MULT_STATE_OUT,
   output logic       TX_SLEEP_OUT,
   output logic       MULT_SLEEP_OUT,
   output logic       THREE_WIRE_OUT
);
   logic [4:0]  rise;
   logic [4:0]  fall;
   logic [7:0]  intf_cfg_reg;
   logic [7:0]  tx_setup_reg;
   logic [7:0]  tx_depth_reg;
   logic [7:0]  mult_setup_reg;
   logic [7:0]  tx_ptr_reg;
   logic [4:0]  mult_ptr_reg;
   logic [7:0]  tx_applied_reg;
   logic [4:0]  mult_applied_reg;
   logic        tx_sleep_reg;
   logic        mult_sleep_reg;
   logic [4:0]  bit_cnt_reg;
   logic [22:0] shift_in_reg;
   logic [7:0]  shift_out_reg;
   logic        rd_reg;
   logic        drive_reg;
   logic        out_bit_reg;

   // Edges: 0 tx reset, 1 tx adv, 2 mult reset, 3 mult adv, 4 sclk
   pulse_edge edges (
      .clk_in   (CLK_IN),
      .srst_in  (SRST_IN),
      .level_in ({LINK.sclk, LINK.mult_adv, LINK.mult_reset,
                  LINK.tx_adv, LINK.tx_reset}),
      .rise_out (rise),
      .fall_out (fall)
   );

   // Serial decode
   wire         sclk_rise  = rise[4] & ~LINK.cs_n;
   wire         sclk_fall  = fall[4] & ~LINK.cs_n;
   wire         in_bit     = LINK.sdio_level;
   wire         three_wire = ~intf_cfg_reg[SERIAL_OUT_ACTIVE_BIT] &
                             ~intf_cfg_reg[SERIAL_OUT_MIRROR_BIT];
   // Bit 16 ends the instruction; bit 24 ends the frame and writes
   wire         instr_end  = sclk_rise &
                             (bit_cnt_reg == 5'(INSTR_BITS - 1));
   wire         frame_end  = sclk_rise &
                             (bit_cnt_reg == 5'(FRAME_BITS - 1));
   wire [14:0]  rd_addr    = {shift_in_reg[13:0], in_bit};
   wire [14:0]  wr_addr    = shift_in_reg[21:7];
   wire [7:0]   wr_data    = {shift_in_reg[6:0], in_bit};
   wire         wr_en      = frame_end & ~shift_in_reg[22];
   wire         wr_soft    = wr_en & (wr_addr == SOFT_CTRL_ADDR);
   // Unmapped addresses read back as zero
   wire [7:0]   rd_data    =
      (rd_addr == INTF_CFG_ADDR)    ? intf_cfg_reg :
      (rd_addr == TX_SETUP_ADDR)    ? tx_setup_reg :
      (rd_addr == TX_DEPTH_ADDR)    ? tx_depth_reg :
      (rd_addr == MULT_SETUP_ADDR)  ? mult_setup_reg :
      (rd_addr == TX_STATUS_ADDR)   ? tx_applied_reg :
      (rd_addr == MULT_STATUS_ADDR) ? {3'h0, mult_applied_reg} : 8'h00;

   // Sequencer controls
   wire soft_rst  = wr_soft & wr_data[SOFT_RESET_BIT];
   wire soft_adv  = wr_soft & wr_data[SOFT_ADV_BIT];
   wire tx_link   = tx_setup_reg[SLEEP_LINK_BIT];
   wire mult_link = mult_setup_reg[SLEEP_LINK_BIT];
   wire tx_hold   = tx_setup_reg[SLEEP_HOLD_BIT];
   wire mult_hold = mult_setup_reg[SLEEP_HOLD_BIT];
   wire tx_byp    = tx_setup_reg[LATCH_BYPASS_BIT];
   wire mult_byp  = mult_setup_reg[LATCH_BYPASS_BIT];
   // Forced asleep by the other sequencer sitting in state 0
   wire tx_forced   = tx_link & (mult_ptr_reg == 5'h00);
   wire mult_forced = mult_link & (tx_ptr_reg == 8'h00);
   wire tx_do_rst   = rise[0] | soft_rst;
   wire mult_do_rst = rise[2];
   // Without hold a forced-asleep counter still advances
   wire tx_do_adv   = (rise[1] | soft_adv) &
                      ~(tx_hold & tx_forced);
   wire mult_do_adv = rise[3] & ~(mult_hold & mult_forced);
   // Reset beats advance when both rise in one cycle
   wire [7:0] tx_ptr_next =
      tx_do_rst ? 8'h00 :
      tx_do_adv ? step_ptr(tx_ptr_reg, {1'b0, tx_depth_reg[6:0]}) :
      tx_ptr_reg;
   wire [4:0] mult_ptr_next =
      mult_do_rst ? 5'h00 :
      mult_do_adv ? 5'(step_ptr({3'h0, mult_ptr_reg},
                                {4'h0, mult_setup_reg[3:0]})) :
      mult_ptr_reg;
   // Latch opens on a pin falling edge, or every cycle when bypassed
   wire tx_apply   = tx_byp | fall[0] | fall[1];
   wire mult_apply = mult_byp | fall[2] | fall[3];
   wire [7:0] tx_applied_next   = tx_apply ? tx_ptr_reg : tx_applied_reg;
   wire [4:0] mult_applied_next = mult_apply ? mult_ptr_reg :
                                               mult_applied_reg;

   // Register writes
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         intf_cfg_reg   <= INTF_CFG_RST;
         tx_setup_reg   <= TX_SETUP_RST;
         tx_depth_reg   <= TX_DEPTH_RST;
         mult_setup_reg <= MULT_SETUP_RST;
      end else if (wr_en) begin
         if (wr_addr == INTF_CFG_ADDR)   intf_cfg_reg   <= wr_data;
         if (wr_addr == TX_SETUP_ADDR)   tx_setup_reg   <= wr_data;
         if (wr_addr == TX_DEPTH_ADDR)   tx_depth_reg   <= wr_data;
         if (wr_addr == MULT_SETUP_ADDR) mult_setup_reg <= wr_data;
      end
   end

   // Pointers and applied states
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         tx_ptr_reg       <= 8'h00;
         mult_ptr_reg     <= 5'h00;
         tx_applied_reg   <= 8'h00;
         mult_applied_reg <= 5'h00;
         tx_sleep_reg     <= 1'b1;
         mult_sleep_reg   <= 1'b1;
      end else begin
         tx_ptr_reg       <= tx_ptr_next;
         mult_ptr_reg     <= mult_ptr_next;
         tx_applied_reg   <= tx_applied_next;
         mult_applied_reg <= mult_applied_next;
         // Sleep follows the applied states, so it moves with the outputs
         tx_sleep_reg     <= (tx_applied_next == 8'h00) |
                             (tx_link &
                              (mult_applied_next == 5'h00));
         mult_sleep_reg   <= (mult_applied_next == 5'h00) |
                             (mult_link & (tx_applied_next == 8'h00));
      end
   end

   // Serial shift in and bit count
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN | LINK.cs_n) begin
         bit_cnt_reg  <= 5'h00;
         shift_in_reg <= 23'h000000;
      end else if (sclk_rise & (bit_cnt_reg != 5'(FRAME_BITS))) begin
         bit_cnt_reg  <= bit_cnt_reg + 5'h01;
         shift_in_reg <= {shift_in_reg[21:0], in_bit};
      end
   end

   // Serial read data, shifted out after each falling clock edge
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN | LINK.cs_n) begin
         rd_reg        <= 1'b0;
         drive_reg     <= 1'b0;
         out_bit_reg   <= 1'b0;
         shift_out_reg <= 8'h00;
      end else if (instr_end) begin
         rd_reg        <= shift_in_reg[14];
         shift_out_reg <= rd_data;
      end else if (sclk_fall & rd_reg & (bit_cnt_reg < 5'(FRAME_BITS))) begin
         drive_reg     <= 1'b1;
         out_bit_reg   <= shift_out_reg[7];
         shift_out_reg <= {shift_out_reg[6:0], 1'b0};
      end
   end

   // One bit register feeds both data lines; the mode picks the enable
   assign LINK.dev_sdio_out = out_bit_reg;
   assign LINK.dev_sdo_out  = out_bit_reg;
   assign LINK.dev_sdio_oe  = drive_reg & three_wire;
   assign LINK.dev_sdo_oe   = drive_reg & ~three_wire;

   // Applied states and sleep flags to the controlled blocks
   assign TX_STATE_OUT   = tx_applied_reg;
   assign MULT_STATE_OUT = mult_applied_reg;
   assign TX_SLEEP_OUT   = tx_sleep_reg;
   assign MULT_SLEEP_OUT = mult_sleep_reg;
   assign THREE_WIRE_OUT = three_wire;
endmodule : seq_device

// ==== core/seq_controller.sv ====
// Controller end: drives sequencer pulses and serial frames on the
// link, commanded by software over APB. Assumes one device per link.
`timescale 1ns/1ps
module seq_controller
   import seq_pkg::*;
(
   // Clock and reset
   input  wire logic        CLK_IN,
   input  wire logic        SRST_IN,
   // APB slave
   input  wire logic        PSEL_IN,
   input  wire logic        PENABLE_IN,
   input  wire logic        PWRITE_IN,
   input  wire logic [11:0] PADDR_IN,
   input  wire logic [31:0] PWDATA_IN,
   output logic      [31:0] PRDATA_OUT,
   output logic             PREADY_OUT,
   output logic             PSLVERR_OUT,
   // Link to device
   seq_link_if.host         LINK
);
   pulse_state_t pstate_reg;
   spi_state_t   sstate_reg;
   logic [4:0]   cmd_reg;
   logic [3:0]   pcnt_reg;
   logic [23:0]  frame_reg;
   logic [7:0]   rx_reg;
   logic [4:0]   bit_cnt_reg;
   logic [3:0]   div_reg;
   logic         sclk_reg;
   logic         cs_n_reg;
   logic         three_wire_reg;
   logic [31:0]  prdata_reg;
   logic         rd_frame_reg;

   // APB decode
   wire access   = PSEL_IN & PENABLE_IN;
   wire setup    = PSEL_IN & ~PENABLE_IN;
   wire mapped   = (PADDR_IN == PULSE_OFS) | (PADDR_IN == SPI_CMD_OFS) |
                   (PADDR_IN == STATUS_OFS) | (PADDR_IN == CFG_OFS);
   wire wr       = access & PWRITE_IN;
   wire p_busy   = (pstate_reg != P_IDLE);
   wire s_busy   = (sstate_reg != SPI_IDLE);
   wire p_start  = wr & (PADDR_IN == PULSE_OFS) & ~p_busy;
   wire s_start  = wr & (PADDR_IN == SPI_CMD_OFS) & ~s_busy;
   wire [31:0] rd_mux =
      (PADDR_IN == STATUS_OFS) ? {16'h0000, rx_reg, 6'h00, p_busy, s_busy} :
      (PADDR_IN == CFG_OFS)    ? {31'h00000000, three_wire_reg} :
                                 32'h00000000;
   wire tick     = s_busy & (div_reg == 4'(SPI_HALF_CYC - 1));
   wire wake     = cmd_reg[PB_WAKE];
   wire [3:0] pcnt_last =
      (pstate_reg == P_LEAD) ? 4'(STAGGER_CYC - 1) :
      (pstate_reg == P_HIGH) ? 4'(PULSE_HI_CYC - 1) :
                               4'(PULSE_LO_CYC - 1);
   wire p_done   = (pcnt_reg == pcnt_last);
   wire miso     = three_wire_reg ? LINK.sdio_level : LINK.sdo_level;

   // APB registers
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         three_wire_reg <= CFG_RST;
         prdata_reg     <= 32'h00000000;
      end else begin
         if (wr & (PADDR_IN == CFG_OFS)) three_wire_reg <= PWDATA_IN[0];
         if (setup) prdata_reg <= rd_mux;
      end
   end

   // Pulse engine: a wake pulses the controlling advance first
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         pstate_reg <= P_IDLE;
         cmd_reg    <= 5'h00;
         pcnt_reg   <= 4'h0;
      end else begin
         pcnt_reg <= (p_start | p_done) ? 4'h0 : pcnt_reg + 4'h1;
         case (pstate_reg)
            P_IDLE: begin
               if (p_start) begin
                  cmd_reg    <= PWDATA_IN[4:0];
                  pstate_reg <= PWDATA_IN[PB_WAKE] ? P_LEAD : P_HIGH;
               end
            end
            P_LEAD: if (p_done) pstate_reg <= P_HIGH;
            P_HIGH: if (p_done) pstate_reg <= P_LOW;
            P_LOW:  if (p_done) pstate_reg <= P_IDLE;
            default: pstate_reg <= P_IDLE;
         endcase
      end
   end

   wire lead_or_high = (pstate_reg == P_LEAD) | (pstate_reg == P_HIGH);
   wire high         = (pstate_reg == P_HIGH);
   assign LINK.tx_reset   = high & cmd_reg[PB_TX_RESET];
   assign LINK.tx_adv     = high & (cmd_reg[PB_TX_ADV] | wake);
   assign LINK.mult_reset = high & cmd_reg[PB_MULT_RESET];
   assign LINK.mult_adv   = lead_or_high & (cmd_reg[PB_MULT_ADV] | wake);

   // Serial engine: 24-bit frame, MSB first, sampled on rising sclk
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         sstate_reg  <= SPI_IDLE;
         frame_reg   <= 24'h000000;
         rx_reg      <= 8'h00;
         bit_cnt_reg <= 5'h00;
         div_reg     <= 4'h0;
         sclk_reg    <= 1'b0;
         cs_n_reg    <= 1'b1;
         rd_frame_reg <= 1'b0;
      end else begin
         div_reg <= (tick | ~s_busy) ? 4'h0 : div_reg + 4'h1;
         case (sstate_reg)
            SPI_IDLE: begin
               if (s_start) begin
                  frame_reg   <= PWDATA_IN[23:0];
                  rd_frame_reg <= PWDATA_IN[23];
                  bit_cnt_reg <= 5'h00;
                  cs_n_reg    <= 1'b0;
                  sstate_reg  <= SPI_SHIFT;
               end
            end
            SPI_SHIFT: begin
               if (tick & ~sclk_reg) begin
                  sclk_reg    <= 1'b1;
                  rx_reg      <= {rx_reg[6:0], miso};
                  bit_cnt_reg <= bit_cnt_reg + 5'h01;
               end else if (tick) begin
                  if (bit_cnt_reg == 5'(FRAME_BITS)) begin
                     sstate_reg <= SPI_STOP;
                  end else begin
                     sclk_reg  <= 1'b0;
                     frame_reg <= {frame_reg[22:0], 1'b0};
                  end
               end
            end
            SPI_STOP: begin
               if (tick) begin
                  sclk_reg   <= 1'b0;
                  cs_n_reg   <= 1'b1;
                  sstate_reg <= SPI_IDLE;
               end
            end
            default: sstate_reg <= SPI_IDLE;
         endcase
      end
   end

   // Release the shared line for read data in three-wire mode, only
   // after the device has sampled bit 16, so the two ends never overlap
   wire read_phase = rd_frame_reg &
                     ((bit_cnt_reg > 5'(INSTR_BITS)) |
                      ((bit_cnt_reg == 5'(INSTR_BITS)) & ~sclk_reg));
   assign LINK.sclk          = sclk_reg;
   assign LINK.cs_n          = cs_n_reg;
   assign LINK.host_sdio_out = frame_reg[23];
   assign LINK.host_sdio_oe  = (sstate_reg == SPI_SHIFT) &
                               ~(three_wire_reg & read_phase);

   assign PRDATA_OUT  = prdata_reg;
   assign PREADY_OUT  = 1'b1;
   assign PSLVERR_OUT = access & ~mapped;
endmodule : seq_controller

// ==== sim/seq_link_properties.sv ====
// Checker for the pulse and serial lines between controller and device.
// Assumes all lines are sampled on the one system clock.
`timescale 1ns/1ps
module seq_link_properties (
   // Clock and reset
   input wire logic CLK_IN,
   input wire logic SRST_IN,
   // Link lines
   input wire logic tx_reset,
   input wire logic tx_adv,
   input wire logic mult_reset,
   input wire logic mult_adv,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic host_sdio_oe,
   input wire logic dev_sdio_oe,
   input wire logic dev_sdo_oe
);
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (SRST_IN);

   AST_WAKE_ORDER: assert property (
      $rose(tx_adv) && mult_adv |-> $past(mult_adv))
      else $error("tx advance rose with multiplier advance");
   AST_ADV_PULSE: assert property (
      $rose(tx_adv) |-> tx_adv [*2] ##1 !tx_adv [*2])
      else $error("tx advance pulse shape wrong");
   AST_RST_PULSE: assert property (
      $rose(tx_reset) |-> tx_reset [*2] ##1 !tx_reset [*2])
      else $error("tx reset pulse shape wrong");
   AST_MULTIPLIER_RESET_PIN_PULSE: assert property (
      $rose(mult_reset) |-> mult_reset [*2] ##1 !mult_reset)
      else $error("multiplier reset pulse shape wrong");
   AST_IDLE_AFTER_RST: assert property (
      $fell(SRST_IN) |-> !tx_reset && !tx_adv && !mult_reset && !mult_adv
         && cs_n && !sclk)
      else $error("lines not idle after reset");
   AST_SCLK_FRAME: assert property (
      sclk |-> !cs_n)
      else $error("serial clock high outside a frame");
   AST_SCLK_HALF: assert property (
      $rose(sclk) |-> sclk [*4])
      else $error("serial clock high phase too short");
   AST_FRAME_START: assert property (
      $fell(cs_n) |-> !sclk && host_sdio_oe)
      else $error("frame start without host driving data");
   AST_NO_CONTEND: assert property (
      !(host_sdio_oe && dev_sdio_oe))
      else $error("both ends drive the shared data line");
   AST_DEV_RELEASE: assert property (
      cs_n && $past(cs_n) |-> !dev_sdio_oe && !dev_sdo_oe)
      else $error("device drives while not selected");
   AST_ONE_LINE: assert property (
      !(dev_sdio_oe && dev_sdo_oe))
      else $error("device drives both data lines");
endmodule : seq_link_properties

// ==== sim/testbench.sv ====
// Bench: APB master for the controller, monitors on the device outputs.
// Assumes one controller and one device joined by the link interface.
`timescale 1ns/1ps
module testbench;
   import seq_pkg::*;
   localparam logic [4:0] TXR = 5'(1 << PB_TX_RESET);
   localparam logic [4:0] TXA = 5'(1 << PB_TX_ADV);
   localparam logic [4:0] MR  = 5'(1 << PB_MULT_RESET);
   localparam logic [4:0] WK  = 5'(1 << PB_WAKE);
   logic        clk;
   logic        srst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [7:0]  tx_state;
   logic [4:0]  mult_state;
   logic        tx_sleep;
   logic        mult_sleep;
   logic        three_wire;
   logic        rd_chk;
   logic [7:0]  st_prev;
   logic [31:0] r;
   logic [11:0] bad_a;
   logic [7:0]  dep;
   logic [15:0] st_q[$];
   logic [33:0] rd_q[$];
   int          bad_count;
   int          checks;

   seq_link_if link ();
   seq_controller seq_controller_i (
      .CLK_IN(clk),
      .SRST_IN(srst),
      .PSEL_IN(psel),
      .PENABLE_IN(penable),
      .PWRITE_IN(pwrite),
      .PADDR_IN(paddr),
      .PWDATA_IN(pwdata),
      .PRDATA_OUT(prdata),
      .PREADY_OUT(pready),
      .PSLVERR_OUT(pslverr),
      .LINK(link)
   );
   seq_device seq_device_i (
      .CLK_IN(clk),
      .SRST_IN(srst),
      .LINK(link),
      .TX_STATE_OUT(tx_state),
      .MULT_STATE_OUT(mult_state),
      .TX_SLEEP_OUT(tx_sleep),
      .MULT_SLEEP_OUT(mult_sleep),
      .THREE_WIRE_OUT(three_wire)
   );
   seq_link_properties seq_link_properties_i (
      .CLK_IN(clk),
      .SRST_IN(srst),
      .tx_reset(link.tx_reset),
      .tx_adv(link.tx_adv),
      .mult_reset(link.mult_reset),
      .mult_adv(link.mult_adv),
      .sclk(link.sclk),
      .cs_n(link.cs_n),
      .host_sdio_oe(link.host_sdio_oe),
      .dev_sdio_oe(link.dev_sdio_oe),
      .dev_sdo_oe(link.dev_sdo_oe)
   );

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : finish_test

   // State word: mult sleep, tx sleep, zero, mult state, tx state
   task automatic cmp_state(input logic [15:0] got);
      logic [15:0] e;
      e = (st_q.size() > 0) ? st_q.pop_front() : {16{1'bX}};
      checks++;
      if (got !== e) begin
         bad_count++;
         $display("[ERR] %0t state got %h exp %h", $time, got, e);
      end
   endtask : cmp_state

   task automatic cmp_read(input logic [33:0] got);
      logic [33:0] e;
      e = (rd_q.size() > 0) ? rd_q.pop_front() : 34'hX_XXXX_XXXX;
      checks++;
      if (got !== e) begin
         bad_count++;
         $display("[ERR] %0t read got %h exp %h", $time, got, e);
      end
   endtask : cmp_read

   // One APB transfer; read data lands in r
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic chk);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      rd_chk  <= chk;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
      rd_chk  <= 1'b0;
   endtask : apb

   task automatic poll(input int b);
      do begin
         apb(1'b0, STATUS_OFS, $urandom, 1'b0);
      end while (r[b] !== 1'b0);
   endtask : poll

   task automatic pulse(input logic [4:0] p);
      apb(1'b1, PULSE_OFS, {27'($urandom), p}, 1'b0);
      poll(1);
   endtask : pulse

   task automatic spi(input logic rd, input logic [14:0] a,
                      input logic [7:0] d);
      apb(1'b1, SPI_CMD_OFS, {8'($urandom), rd, a, d}, 1'b0);
      poll(0);
   endtask : spi

   task automatic rd_exp(input logic [11:0] a, input logic [33:0] e);
      rd_q.push_back(e);
      apb(1'b0, a, $urandom, 1'b1);
   endtask : rd_exp

   // Result monitor: tx applied state changes and checked reads
   always @(posedge clk) begin
      if (srst)
         st_prev = tx_state;
      else if (tx_state !== st_prev) begin
         cmp_state({mult_sleep, tx_sleep, 1'b0, mult_state, tx_state});
         st_prev = tx_state;
      end
      if (psel && penable && pready === 1'b1 && !pwrite && rd_chk)
         cmp_read({three_wire, pslverr, prdata});
   end

   initial begin
      repeat (60000) @(posedge clk);
      bad_count++;
      finish_test;
   end

   initial begin
      srst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      rd_chk = 1'b0;
      bad_count = 0;
      checks = 0;
      void'($urandom(32'hDB50E80E));
      dep = 8'(2 + $urandom % 5);
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      rd_exp(CFG_OFS, {2'b00, 31'h0, CFG_RST});
      spi(1'b0, TX_DEPTH_ADDR, dep);
      for (int i = 0; i <= dep + 1; i++) begin
         st_q.push_back(16'h8000 | 16'(i % (dep + 1) + 1));
         pulse(TXA);
      end
      st_q.push_back(16'hC000);
      pulse(TXR);
      spi(1'b0, SOFT_CTRL_ADDR, 8'h01);
      st_q.push_back(16'h8002);
      pulse(TXA);
      spi(1'b0, SOFT_CTRL_ADDR, 8'h02);
      st_q.push_back(16'h8001);
      pulse(TXA);
      spi(1'b0, TX_DEPTH_ADDR, 8'h3F);
      for (int i = 2; i <= 64; i++) begin
         st_q.push_back(16'h8000 | 16'(i));
         pulse(TXA);
      end
      st_q.push_back(16'h8001);
      pulse(TXA);
      spi(1'b0, TX_DEPTH_ADDR, dep);
      $display("test pointer done");
      spi(1'b0, TX_SETUP_ADDR, 8'h60);
      pulse(TXA);
      spi(1'b0, SOFT_CTRL_ADDR, 8'h01);
      pulse(TXA);
      st_q.push_back(16'hC000);
      pulse(TXR);
      st_q.push_back(16'h0101);
      pulse(WK);
      spi(1'b0, TX_SETUP_ADDR, 8'h40);
      pulse(MR);
      st_q.push_back(16'hC002);
      pulse(TXA);
      spi(1'b0, TX_SETUP_ADDR, 8'h10);
      st_q.push_back(16'h8003);
      pulse(TXA);
      st_q.push_back(16'hC000);
      pulse(TXR | TXA);
      $display("test hold and bypass done");
      spi(1'b0, MULT_SETUP_ADDR, 8'h10);
      spi(1'b1, TX_SETUP_ADDR, 8'h00);
      rd_exp(STATUS_OFS, {2'b00, 32'h0000_1000});
      spi(1'b1, MULT_SETUP_ADDR, 8'h00);
      rd_exp(STATUS_OFS, {2'b00, 32'h0000_1000});
      spi(1'b0, INTF_CFG_ADDR, 8'h00);
      apb(1'b1, CFG_OFS, 32'h1, 1'b0);
      rd_exp(CFG_OFS, {2'b10, 32'h1});
      spi(1'b1, TX_DEPTH_ADDR, 8'h00);
      rd_exp(STATUS_OFS, {2'b10, 16'h0000, dep, 8'h00});
      bad_a = 12'h010 + 12'(($urandom % 1000) * 4);
      apb(1'b1, bad_a, $urandom, 1'b0);
      rd_exp(bad_a, {2'b11, 32'h0});
      $display("test registers done");
      repeat (10) @(posedge clk);
      checks++;
      if (st_q.size() != 0 || rd_q.size() != 0) begin
         bad_count++;
         $display("[ERR] %0t left %h exp %h", $time,
                  st_q.size() + rd_q.size(), 0);
      end
      finish_test;
   end
endmodule : testbench
